// *** logic/pwmch_pkg.sv ***
/*
 * Constants shared by the 16-bit modulator channel: register offsets, field
 * positions, reset values and mode encodings.
 * Assumes an 8-bit register port with one-cycle read latency.
 */
package pwmch_pkg;
    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [3:0] ADDR_CTRL    = 4'h0;
    localparam logic [3:0] ADDR_FLAGS   = 4'h1;
    localparam logic [3:0] ADDR_CLKCON  = 4'h2;
    localparam logic [3:0] ADDR_RELOAD  = 4'h3;
    localparam logic [3:0] ADDR_OFFCON  = 4'h4;
    localparam logic [3:0] ADDR_PH_LO   = 4'h5;
    localparam logic [3:0] ADDR_PH_HI   = 4'h6;
    localparam logic [3:0] ADDR_DC_LO   = 4'h7;
    localparam logic [3:0] ADDR_DC_HI   = 4'h8;
    localparam logic [3:0] ADDR_PR_LO   = 4'h9;
    localparam logic [3:0] ADDR_PR_HI   = 4'ha;
    localparam logic [3:0] ADDR_OF_LO   = 4'hb;
    localparam logic [3:0] ADDR_OF_HI   = 4'hc;
    localparam logic [3:0] ADDR_TMR_LO  = 4'hd;
    localparam logic [3:0] ADDR_TMR_HI  = 4'he;
    // ------------------------------------------------------------
    // Control, clock, reload and offset register fields
    // ------------------------------------------------------------
    localparam int CTRL_EN   = 7;
    localparam int CTRL_OE   = 6;
    localparam int CTRL_OUT  = 5;
    localparam int CTRL_POL  = 4;
    localparam int CTRL_MODE = 2;
    localparam int CLK_PS    = 4;
    localparam int LD_ARMED  = 7;
    localparam int LD_TRIG   = 6;
    localparam int OF_MODE   = 5;
    localparam int OF_DIR    = 4;
    localparam int OF_SEL    = 0;
    // ------------------------------------------------------------
    // Encodings and reset values
    // ------------------------------------------------------------
    localparam logic [1:0] MODE_STD    = 2'h0;
    localparam logic [1:0] MODE_SET    = 2'h1;
    localparam logic [1:0] MODE_TOGGLE = 2'h2;
    localparam logic [1:0] MODE_CENTER = 2'h3;
    localparam logic [1:0] OFM_INDEP   = 2'h0;
    localparam logic [1:0] OFM_SLAVE   = 2'h1;
    localparam logic [1:0] OFM_ONESHOT = 2'h2;
    localparam logic [1:0] OFM_CONT    = 2'h3;
    localparam logic [1:0] SEL_NONE    = 2'h0;
    localparam logic [7:0] REG_RESET   = 8'h00;
    localparam logic [15:0] CNT_RESET  = 16'h0000;
    localparam logic [15:0] CNT_ONE    = 16'h0001;
endpackage

// *** logic/pwmch_channel.sv ***
/*
 * One 16-bit modulator channel: four output modes, four offset modes,
 * double-buffered counts with immediate or triggered reload.
 * Assumes the sibling offset-match and load events arrive from another
 * clock domain and are synchronised here; the master is never faster.
 */
// What this block does
// - Polarity inverts pin even when disabled
// - Standard: active at phase, inactive at duty
// - Standard: period match resets timer
// - Set mode: phase sets, software or disable clears
// - Set mode: period bounds timer maximum
// - Set mode: output bit write at next tick
// - Toggle mode: toggle on phase match
// - Toggle, center modes ignore output-bit writes
// - Center mode counts up then down
// - Center: on at pr-dc up, off plus one down
// - Independent offset: free run, period resets
// - Slave run: wait master match, then run
// - One-shot slave: outside center mode, run one period per match
// - One-shot: matches during running period ignored
// - Continuous slave: matches reload timer to one
// - Center master: direction bit picks offset edge
// - Counts and direction double-buffered, loaded together
// - Immediate load at next period after arming
// - Triggered load waits sibling load event
// - Transfer clears the armed bit
// - Arming at period match defers load
// - Flags set on match rising edge
// - Flags held clear while disabled
// - Prescaler divides by two to field power
// - Trigger select picks sibling; zero reserved
`timescale 1ns/1ps
module pwmch_channel #(
    parameter logic [1:0] CHAN_ID = 2'h1
) (
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    input  wire logic [3:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    input  wire logic [3:1] master_offset_match,
    input  wire logic [3:1] sibling_load_trigger,
    output logic            pwm_out,
    output logic            pwm_oe,
    output logic            offset_match_out,
    output logic            load_event_out
);
    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic [3:1] ofm_s1_r, ofm_s2_r, ofm_s3_r, ldt_s1_r, ldt_s2_r, ldt_s3_r;
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ofm_s1_r <= 3'h0; ofm_s2_r <= 3'h0; ofm_s3_r <= 3'h0;
            ldt_s1_r <= 3'h0; ldt_s2_r <= 3'h0; ldt_s3_r <= 3'h0;
        end
        else
        begin
            ofm_s1_r <= master_offset_match; ofm_s2_r <= ofm_s1_r; ofm_s3_r <= ofm_s2_r;
            ldt_s1_r <= sibling_load_trigger; ldt_s2_r <= ldt_s1_r; ldt_s3_r <= ldt_s2_r;
        end
    end
    // ------------------------------------------------------------
    // Registers and state
    // ------------------------------------------------------------
    logic [7:0]  ctrl_r, ctrl_nxt, clk_r, clk_nxt, ld_r, ld_nxt, of_r, of_nxt;
    logic [3:0]  flags_r, flags_nxt;
    logic [15:0] ph_b_r, ph_b_nxt, dc_b_r, dc_b_nxt, pr_b_r, pr_b_nxt, ofc_b_r, ofc_b_nxt;
    logic [15:0] ph_r, ph_nxt, dc_r, dc_nxt, pr_r, pr_nxt, ofc_r, ofc_nxt;
    logic        ofo_r, ofo_nxt;
    logic [15:0] tmr_r, tmr_nxt;
    logic        down_r, down_nxt, run_r, run_nxt, act_r, act_nxt;
    logic        trig_seen_r, trig_seen_nxt, arm_new_r, arm_new_nxt;
    logic [6:0]  pre_r, pre_nxt;
    logic [3:0]  match_r, match_nxt;
    logic        pin_r, pin_nxt, oe_r, oe_nxt, ofo_out_r, ofo_out_nxt, lde_r, lde_nxt;
    logic [7:0]  rdata_r, rdata_nxt;
    logic        out_wr_r, out_wr_nxt, out_val_r, out_val_nxt;

    logic        en, tick, ph_m, dc_m, pr_m, of_m, per_ev, mst, sel_trig, do_load;
    logic [1:0]  mode, offset_mode_field;
    logic [15:0] ca_val;
    logic [3:0]  match_now;

    always_comb
    begin
        en   = ctrl_r[pwmch_pkg::CTRL_EN];
        mode = ctrl_r[pwmch_pkg::CTRL_MODE +: 2];
        offset_mode_field  = of_r[pwmch_pkg::OF_MODE +: 2];
        tick = (pre_r & ((7'h01 << clk_r[pwmch_pkg::CLK_PS +: 3]) - 7'h01)) == 7'h00;
        ca_val = pr_r - dc_r;
        if (mode == pwmch_pkg::MODE_CENTER)
        begin
            ph_m = !down_r && (tmr_r == ca_val);
            dc_m = down_r && (tmr_r == ca_val + pwmch_pkg::CNT_ONE);
            pr_m = !down_r && (tmr_r == pr_r);
            of_m = (tmr_r == ofc_r) && (down_r == ofo_r);
            per_ev = down_r && (tmr_r == pwmch_pkg::CNT_RESET);
        end
        else
        begin
            ph_m = tmr_r == ph_r;
            dc_m = tmr_r == dc_r;
            pr_m = tmr_r == pr_r;
            of_m = tmr_r == ofc_r;
            per_ev = pr_m;
        end
        ph_m = ph_m && en;
        dc_m = dc_m && en;
        pr_m = pr_m && en;
        of_m = of_m && en;
        per_ev = per_ev && en && tick && run_r;
        mst = (of_r[pwmch_pkg::OF_SEL +: 2] != pwmch_pkg::SEL_NONE)
            && (of_r[pwmch_pkg::OF_SEL +: 2] != CHAN_ID)
            && ofm_s2_r[of_r[pwmch_pkg::OF_SEL +: 2]] && !ofm_s3_r[of_r[pwmch_pkg::OF_SEL +: 2]];
        sel_trig = (ld_r[1:0] != pwmch_pkg::SEL_NONE) && (ld_r[1:0] != CHAN_ID)
            && ldt_s2_r[ld_r[1:0]] && !ldt_s3_r[ld_r[1:0]];
        do_load = per_ev && ld_r[pwmch_pkg::LD_ARMED] && !arm_new_r
            && (!ld_r[pwmch_pkg::LD_TRIG] || trig_seen_r);
        match_now = {of_m, ph_m, dc_m, pr_m};
    end

    // ------------------------------------------------------------
    // Register file and buffers
    // ------------------------------------------------------------
    always_comb
    begin
        ctrl_nxt = ctrl_r; clk_nxt = clk_r; ld_nxt = ld_r; of_nxt = of_r;
        ph_b_nxt = ph_b_r; dc_b_nxt = dc_b_r; pr_b_nxt = pr_b_r; ofc_b_nxt = ofc_b_r;
        ph_nxt = ph_r; dc_nxt = dc_r; pr_nxt = pr_r; ofc_nxt = ofc_r; ofo_nxt = ofo_r;
        // deferral holds until the period event it skips
        arm_new_nxt = arm_new_r && !per_ev;
        // Pending output-bit write retires on the tick; a new write below re-arms it
        out_wr_nxt = out_wr_r && !tick;
        out_val_nxt = out_val_r;
        trig_seen_nxt = trig_seen_r || sel_trig;
        // flags set on rising match, held clear when off
        flags_nxt = en ? (flags_r | (match_now & ~match_r)) : 4'h0;
        if (reg_wr)
        begin
            case (reg_addr)
                pwmch_pkg::ADDR_CTRL:
                begin
                    ctrl_nxt = {reg_wdata[7:2], 2'h0};
                    ctrl_nxt[pwmch_pkg::CTRL_OUT] = ctrl_r[pwmch_pkg::CTRL_OUT];
                    // output bit write only in set mode
                    if (mode == pwmch_pkg::MODE_SET)
                    begin
                        out_wr_nxt = 1'b1;
                        out_val_nxt = reg_wdata[pwmch_pkg::CTRL_OUT];
                    end
                end
                pwmch_pkg::ADDR_FLAGS:  flags_nxt = flags_nxt & reg_wdata[3:0] & (flags_r | (match_now & ~match_r)) | (match_now & ~match_r & {4{en}});
                pwmch_pkg::ADDR_CLKCON: clk_nxt = {1'b0, reg_wdata[6:4], 4'h0};
                pwmch_pkg::ADDR_RELOAD:
                begin
                    ld_nxt = {reg_wdata[7:6], 4'h0, reg_wdata[1:0]};
                    arm_new_nxt = reg_wdata[pwmch_pkg::LD_ARMED] && pr_m && !per_ev;
                    if (!reg_wdata[pwmch_pkg::LD_ARMED]) trig_seen_nxt = 1'b0;
                end
                pwmch_pkg::ADDR_OFFCON: of_nxt = {1'b0, reg_wdata[6:5], 3'h0, reg_wdata[1:0]};
                pwmch_pkg::ADDR_PH_LO:  ph_b_nxt[7:0]  = reg_wdata;
                pwmch_pkg::ADDR_PH_HI:  ph_b_nxt[15:8] = reg_wdata;
                pwmch_pkg::ADDR_DC_LO:  dc_b_nxt[7:0]  = reg_wdata;
                pwmch_pkg::ADDR_DC_HI:  dc_b_nxt[15:8] = reg_wdata;
                pwmch_pkg::ADDR_PR_LO:  pr_b_nxt[7:0]  = reg_wdata;
                pwmch_pkg::ADDR_PR_HI:  pr_b_nxt[15:8] = reg_wdata;
                pwmch_pkg::ADDR_OF_LO:  ofc_b_nxt[7:0]  = reg_wdata;
                pwmch_pkg::ADDR_OF_HI:  ofc_b_nxt[15:8] = reg_wdata;
                default: ;
            endcase
            if (reg_addr == pwmch_pkg::ADDR_OFFCON)
                ld_nxt[5] = 1'b0;
        end
        // Direction bit is buffered alongside the counts
        if (reg_wr && reg_addr == pwmch_pkg::ADDR_OFFCON)
            of_nxt[pwmch_pkg::OF_DIR] = reg_wdata[pwmch_pkg::OF_DIR];
        if (do_load)
        begin
            ph_nxt = ph_b_r; dc_nxt = dc_b_r; pr_nxt = pr_b_r; ofc_nxt = ofc_b_r;
            ofo_nxt = of_r[pwmch_pkg::OF_DIR];
            ld_nxt[pwmch_pkg::LD_ARMED] = 1'b0;
            trig_seen_nxt = 1'b0;
        end
        ctrl_nxt[pwmch_pkg::CTRL_OUT] = act_r;
    end

    // ------------------------------------------------------------
    // Timer, output and read path
    // ------------------------------------------------------------
    always_comb
    begin
        pre_nxt = en ? pre_r + 7'h01 : 7'h00;
        tmr_nxt = tmr_r; down_nxt = down_r; run_nxt = run_r; act_nxt = act_r;
        if (!en)
        begin
            tmr_nxt = pwmch_pkg::CNT_RESET; down_nxt = 1'b0; act_nxt = 1'b0;
            run_nxt = (offset_mode_field == pwmch_pkg::OFM_INDEP);
        end
        else
        begin
            if (mst && tick)
            begin
                if (offset_mode_field == pwmch_pkg::OFM_CONT && run_r)
                    tmr_nxt = pwmch_pkg::CNT_ONE;
                if (offset_mode_field != pwmch_pkg::OFM_INDEP)
                    run_nxt = 1'b1;
            end
            if (run_r && tick && !(mst && offset_mode_field == pwmch_pkg::OFM_CONT))
            begin
                if (mode == pwmch_pkg::MODE_CENTER)
                begin
                    // up then down
                    // Top and bottom each hold one tick, so a cycle spans 2 * (pr + 1)
                    if (!down_r && tmr_r >= pr_r)
                        down_nxt = 1'b1;
                    else if (down_r && tmr_r == pwmch_pkg::CNT_RESET)
                        down_nxt = 1'b0;
                    else if (down_r)
                        tmr_nxt = tmr_r - pwmch_pkg::CNT_ONE;
                    else
                        tmr_nxt = tmr_r + pwmch_pkg::CNT_ONE;
                end
                else if (pr_m)
                begin
                    tmr_nxt = pwmch_pkg::CNT_RESET;
                    if (offset_mode_field == pwmch_pkg::OFM_ONESHOT) run_nxt = 1'b0;
                end
                else
                    tmr_nxt = tmr_r + pwmch_pkg::CNT_ONE;
            end
            if (tick && run_r)
            begin
                case (mode)
                    pwmch_pkg::MODE_STD: act_nxt = ph_m ? 1'b1 : (dc_m ? 1'b0 : act_r);
                    pwmch_pkg::MODE_SET: act_nxt = ph_m ? 1'b1 : act_r;
                    pwmch_pkg::MODE_TOGGLE: act_nxt = ph_m ? !act_r : act_r;
                    pwmch_pkg::MODE_CENTER: act_nxt = ph_m ? 1'b1 : (dc_m ? 1'b0 : act_r);
                    default: act_nxt = act_r;
                endcase
            end
            if (out_wr_r && tick && mode == pwmch_pkg::MODE_SET)
                act_nxt = out_val_r;
        end
        pin_nxt = act_nxt ^ ctrl_r[pwmch_pkg::CTRL_POL];
        oe_nxt = ctrl_r[pwmch_pkg::CTRL_OE];
        match_nxt = match_now;
        ofo_out_nxt = of_m;
        lde_nxt = do_load;
        case (reg_addr)
            pwmch_pkg::ADDR_CTRL:   rdata_nxt = ctrl_r;
            pwmch_pkg::ADDR_FLAGS:  rdata_nxt = {4'h0, flags_r};
            pwmch_pkg::ADDR_CLKCON: rdata_nxt = clk_r;
            pwmch_pkg::ADDR_RELOAD: rdata_nxt = ld_r;
            pwmch_pkg::ADDR_OFFCON: rdata_nxt = of_r;
            pwmch_pkg::ADDR_PH_LO:  rdata_nxt = ph_b_r[7:0];
            pwmch_pkg::ADDR_PH_HI:  rdata_nxt = ph_b_r[15:8];
            pwmch_pkg::ADDR_DC_LO:  rdata_nxt = dc_b_r[7:0];
            pwmch_pkg::ADDR_DC_HI:  rdata_nxt = dc_b_r[15:8];
            pwmch_pkg::ADDR_PR_LO:  rdata_nxt = pr_b_r[7:0];
            pwmch_pkg::ADDR_PR_HI:  rdata_nxt = pr_b_r[15:8];
            pwmch_pkg::ADDR_OF_LO:  rdata_nxt = ofc_b_r[7:0];
            pwmch_pkg::ADDR_OF_HI:  rdata_nxt = ofc_b_r[15:8];
            pwmch_pkg::ADDR_TMR_LO: rdata_nxt = tmr_r[7:0];
            pwmch_pkg::ADDR_TMR_HI: rdata_nxt = tmr_r[15:8];
            default:                rdata_nxt = pwmch_pkg::REG_RESET;
        endcase
        if (!reg_rd)
            rdata_nxt = pwmch_pkg::REG_RESET;
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl_r <= 8'h00; clk_r <= 8'h00; ld_r <= 8'h00; of_r <= 8'h00;
            flags_r <= 4'h0; ph_b_r <= 16'h0000; dc_b_r <= 16'h0000;
            pr_b_r <= 16'h0000; ofc_b_r <= 16'h0000; ph_r <= 16'h0000;
            dc_r <= 16'h0000; pr_r <= 16'h0000; ofc_r <= 16'h0000; ofo_r <= 1'b0;
            tmr_r <= 16'h0000; down_r <= 1'b0; run_r <= 1'b1; act_r <= 1'b0;
            trig_seen_r <= 1'b0; arm_new_r <= 1'b0; pre_r <= 7'h00; match_r <= 4'h0;
            pin_r <= 1'b0; oe_r <= 1'b0; ofo_out_r <= 1'b0; lde_r <= 1'b0;
            rdata_r <= 8'h00; out_wr_r <= 1'b0; out_val_r <= 1'b0;
        end
        else
        begin
            ctrl_r <= ctrl_nxt; clk_r <= clk_nxt; ld_r <= ld_nxt; of_r <= of_nxt;
            flags_r <= flags_nxt; ph_b_r <= ph_b_nxt; dc_b_r <= dc_b_nxt;
            pr_b_r <= pr_b_nxt; ofc_b_r <= ofc_b_nxt; ph_r <= ph_nxt;
            dc_r <= dc_nxt; pr_r <= pr_nxt; ofc_r <= ofc_nxt; ofo_r <= ofo_nxt;
            tmr_r <= tmr_nxt; down_r <= down_nxt; run_r <= run_nxt; act_r <= act_nxt;
            trig_seen_r <= trig_seen_nxt; arm_new_r <= arm_new_nxt; pre_r <= pre_nxt;
            match_r <= match_nxt; pin_r <= pin_nxt; oe_r <= oe_nxt;
            ofo_out_r <= ofo_out_nxt; lde_r <= lde_nxt; rdata_r <= rdata_nxt;
            out_wr_r <= out_wr_nxt; out_val_r <= out_val_nxt;
        end
    end

    assign reg_rdata        = rdata_r;
    assign pwm_out          = pin_r;
    assign pwm_oe           = oe_r;
    assign offset_match_out = ofo_out_r;
    assign load_event_out   = lde_r;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    a_flags_clear_off: assert property (!en |=> flags_r == 4'h0) else $error("flags set while off");
    a_pin_polarity: assert property (pwm_out == (act_r ^ $past(ctrl_r[pwmch_pkg::CTRL_POL]))) else $error("polarity wrong");
    a_load_clears_arm: assert property (do_load |=> !ld_r[pwmch_pkg::LD_ARMED]) else $error("armed not cleared");
    a_load_copies: assert property (do_load |=> pr_r == $past(pr_b_r)) else $error("period not loaded");
    a_period_reset: assert property (en && run_r && tick && pr_m && mode != pwmch_pkg::MODE_CENTER && !mst |=> tmr_r == 16'h0000) else $error("timer not reset");
    a_std_on: assert property (en && run_r && tick && ph_m && mode == pwmch_pkg::MODE_STD |=> act_r) else $error("no phase edge");
    a_toggle_flip: assert property (en && run_r && tick && ph_m && mode == pwmch_pkg::MODE_TOGGLE && !out_wr_r |=> act_r != $past(act_r)) else $error("no toggle");
    a_flag_rise: assert property (en && match_now[1] && !match_r[1] && !reg_wr |=> flags_r[1]) else $error("flag missed");
    c_load: cover property (do_load);
    c_center_down: cover property (down_r && en);
    c_master_start: cover property (mst && en);
endmodule // pwmch_channel

// *** test/pwmch_pin_load.sv ***
/*
 * Load on the modulator pin: a pull-down resistor behind the output stage.
 * Assumes pwm_oe is high while the channel drives the pin.
 */
`timescale 1ns/1ps
module pwmch_pin_load (
    input  wire logic pwm_out,
    input  wire logic pwm_oe,
    output logic      pin
);
    // ------------------------------------------------------------
    // Pin level
    // ------------------------------------------------------------
    // A released pin falls to the pull-down level, never the last value driven
    assign pin = pwm_oe ? pwm_out : 1'b0;
endmodule // pwmch_pin_load

// *** test/pwm16_modes_offset_reload_test.sv ***
/*
 * Self-checking bench for one modulator channel: register tasks, pin
 * waveform measured against figures worked out from the counts.
 * Assumes the channel of logic/ and the pull-down pin load model.
 */
`timescale 1ns/1ps
module pwm16_modes_offset_reload_test;
    logic        ref_clk;
    logic        rst_n = 1'b0;
    logic [3:0]  reg_addr = 4'h0;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [3:1]  master_offset_match = 3'h0;
    logic [3:1]  sibling_load_trigger = 3'h0;
    logic [7:0]  reg_rdata;
    logic [7:0]  rv;
    logic        pwm_out, pwm_oe, offset_match_out, load_event_out, pin;
    int          errors = 0, n_checks = 0, cycles = 0, seed = 53151;
    int          pr, ph, dc, k, m, n_loads = 0, n_ofm = 0;
    logic        ofm_q = 1'b0;

    pwmch_channel uut (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .master_offset_match(master_offset_match), .sibling_load_trigger(sibling_load_trigger),
        .pwm_out(pwm_out), .pwm_oe(pwm_oe), .offset_match_out(offset_match_out),
        .load_event_out(load_event_out));
    pwmch_pin_load pin_load (.pwm_out(pwm_out), .pwm_oe(pwm_oe), .pin(pin));

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic summarize();
        $display("errors %0d checks %0d", errors, n_checks);
        if (errors == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge ref_clk);
        reg_wr    <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge ref_clk);
        reg_rd   <= 1'b0;
        @(negedge ref_clk);
        rv = reg_rdata;
    endtask
    task automatic pulse_master(input logic [3:1] v);
        @(posedge ref_clk);
        master_offset_match <= v;
        repeat (4) @(posedge ref_clk);
        master_offset_match <= 3'h0;
    endtask
    // Counts land in the buffers only; they act after the next load
    task automatic load_counts();
        wr(pwmch_pkg::ADDR_PH_LO, ph[7:0]);
        wr(pwmch_pkg::ADDR_PH_HI, ph[15:8]);
        wr(pwmch_pkg::ADDR_DC_LO, dc[7:0]);
        wr(pwmch_pkg::ADDR_DC_HI, dc[15:8]);
        wr(pwmch_pkg::ADDR_PR_LO, pr[7:0]);
        wr(pwmch_pkg::ADDR_PR_HI, pr[15:8]);
    endtask
    task automatic wait_lvl(input logic lvl, output int n);
        n = 0;
        while (pin !== lvl && n < 3000)
        begin
            @(negedge ref_clk);
            n++;
        end
    endtask
    task automatic run_mode(input logic [1:0] mode, input int ps, input int hi, input int per);
        int n, h, l;
        wr(pwmch_pkg::ADDR_CLKCON, 8'(ps << 4));
        load_counts();
        wr(pwmch_pkg::ADDR_RELOAD, 8'h80);
        // Output bit set as well: it must change nothing outside set mode
        wr(pwmch_pkg::ADDR_CTRL, {4'he, mode, 2'h0});
        repeat (3 * per + 8) @(negedge ref_clk);
        wait_lvl(1'b0, n);
        wait_lvl(1'b1, n);
        wait_lvl(1'b0, h);
        wait_lvl(1'b1, l);
        check("active time", h[15:0], hi[15:0]);
        check("period", 16'(h + l), per[15:0]);
        rd(pwmch_pkg::ADDR_RELOAD);
        check("armed bit", rv[7], 1'b0);
        rd(pwmch_pkg::ADDR_FLAGS);
        check("period flag", rv[0], 1'b1);
        wr(pwmch_pkg::ADDR_CTRL, 8'h40);
        rd(pwmch_pkg::ADDR_FLAGS);
        check("flags disabled", rv, 8'h00);
    endtask

    // ------------------------------------------------------------
    // Clock, timeout and sequence
    // ------------------------------------------------------------
    initial
    begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk)
    begin
        cycles <= cycles + 1;
        // Count load pulses and rising offset-match levels from the channel
        ofm_q <= offset_match_out;
        if (load_event_out === 1'b1)
            n_loads <= n_loads + 1;
        if (offset_match_out === 1'b1 && ofm_q !== 1'b1)
            n_ofm <= n_ofm + 1;
        if (cycles == 60000)
        begin
            errors++;
            summarize();
        end
    end
    initial
    begin
        repeat (4) @(posedge ref_clk);
        rst_n <= 1'b1;
        rd(pwmch_pkg::ADDR_CTRL);
        check("control reset", rv, pwmch_pkg::REG_RESET);
        rd(4'hf);
        check("unmapped read", rv, 8'h00);
        wr(pwmch_pkg::ADDR_CTRL, 8'h50);
        repeat (4) @(negedge ref_clk);
        check("inverted idle pin", pin, 1'b1);
        // Period above the largest duty keeps the center-aligned up match in range
        pr = 10 + ($random(seed) & 15);
        ph = 1 + ($random(seed) & 3);
        dc = ph + 2 + ($random(seed) & 3);
        run_mode(pwmch_pkg::MODE_STD, 0, dc - ph, pr + 1);
        run_mode(pwmch_pkg::MODE_STD, 2, 4 * (dc - ph), 4 * (pr + 1));
        run_mode(pwmch_pkg::MODE_TOGGLE, 0, pr + 1, 2 * (pr + 1));
        run_mode(pwmch_pkg::MODE_CENTER, 0, 2 * dc, 2 * (pr + 1));
        // Long period so no second phase match lands near the clear
        pr = 200;
        ph = 3;
        load_counts();
        wr(pwmch_pkg::ADDR_RELOAD, 8'h80);
        wr(pwmch_pkg::ADDR_CTRL, {4'hc, pwmch_pkg::MODE_SET, 2'h0});
        repeat (60) @(negedge ref_clk);
        check("set on match", pin, 1'b1);
        wr(pwmch_pkg::ADDR_CTRL, 8'hc4);
        repeat (3) @(negedge ref_clk);
        check("output bit clear", pin, 1'b0);
        wr(pwmch_pkg::ADDR_CTRL, 8'h40);
        // Select 01 names this channel itself, so its match must be ignored
        wr(pwmch_pkg::ADDR_OFFCON, 8'h21);
        wr(pwmch_pkg::ADDR_CTRL, 8'hc0);
        pulse_master(3'h1);
        repeat (20) @(negedge ref_clk);
        rd(pwmch_pkg::ADDR_TMR_LO);
        check("slave waits", rv, 8'h00);
        wr(pwmch_pkg::ADDR_OFFCON, 8'h22);
        // one slow master pulse, so no match is missed
        pulse_master(3'h2);
        repeat (20) @(negedge ref_clk);
        rd(pwmch_pkg::ADDR_TMR_LO);
        check("slave runs", 16'(rv != 8'h00), 16'h0001);
        wr(pwmch_pkg::ADDR_CTRL, 8'h40);
        wr(pwmch_pkg::ADDR_OFFCON, 8'h42);
        wr(pwmch_pkg::ADDR_CTRL, 8'hc0);
        pulse_master(3'h2);
        repeat (20) @(negedge ref_clk);
        rd(pwmch_pkg::ADDR_TMR_LO);
        check("one-shot runs", 16'(rv != 8'h00), 16'h0001);
        repeat (250) @(negedge ref_clk);
        rd(pwmch_pkg::ADDR_TMR_LO);
        check("one-shot halts", rv, 8'h00);
        wr(pwmch_pkg::ADDR_CTRL, 8'h40);
        // phase is still 3 here, at least one
        wr(pwmch_pkg::ADDR_OFFCON, 8'h62);
        wr(pwmch_pkg::ADDR_CTRL, 8'hc0);
        repeat (20) @(negedge ref_clk);
        rd(pwmch_pkg::ADDR_TMR_LO);
        check("continuous waits", rv, 8'h00);
        pulse_master(3'h2);
        repeat (20) @(negedge ref_clk);
        rd(pwmch_pkg::ADDR_TMR_LO);
        check("continuous runs", 16'(rv != 8'h00), 16'h0001);
        wr(pwmch_pkg::ADDR_CTRL, 8'h40);
        wr(pwmch_pkg::ADDR_OFFCON, 8'h00);
        pr = 30;
        load_counts();
        wr(pwmch_pkg::ADDR_RELOAD, 8'hc2);
        wr(pwmch_pkg::ADDR_CTRL, 8'hc0);
        m = n_ofm;
        repeat (450) @(negedge ref_clk);
        rd(pwmch_pkg::ADDR_RELOAD);
        check("armed awaits trigger", rv[7], 1'b1);
        check("offset match out", 16'(n_ofm > m), 16'h0001);
        k = n_loads;
        @(posedge ref_clk);
        sibling_load_trigger[2] <= 1'b1;
        repeat (4) @(posedge ref_clk);
        sibling_load_trigger[2] <= 1'b0;
        repeat (450) @(negedge ref_clk);
        rd(pwmch_pkg::ADDR_RELOAD);
        check("triggered load", rv[7], 1'b0);
        check("load pulses", 16'(n_loads - k), 16'h0001);
        summarize();
    end
endmodule // pwm16_modes_offset_reload_test
